//--- src/sio_defines.svh
`ifndef SIO_DEFINES_SVH
`define SIO_DEFINES_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SIO_OFF_WAKE       8'h00
`define SIO_OFF_FAIL       8'h04
`define SIO_OFF_SUPPLY     8'h08
`define SIO_OFF_MASK       8'h0C
`define SIO_OFF_STATUS     8'h10
`define SIO_OFF_READ_CMD   8'h14
`define SIO_OFF_MODE       8'h18

// ****************************************
// field positions and codes
// ****************************************
`define SIO_SUMMARY_BIT    3
`define SIO_RD_ONLY_CODE   3'h7
`define SIO_RD_REG_WAKE    3'h0
`define SIO_RD_REG_FAIL    3'h1
`define SIO_RD_REG_SUPPLY  3'h2
`define SIO_NSRC           14
`define SIO_MASK_RESET     14'h3FFF

// ****************************************
// timing
// ****************************************
`define SIO_CLK_MHZ        125
`define SIO_MIN_PULSE_US   10
`define SIO_TIMEOUT_US     5400
`define SIO_MIN_PULSE_CYC  (`SIO_MIN_PULSE_US * `SIO_CLK_MHZ)
`define SIO_TIMEOUT_CYC    (`SIO_TIMEOUT_US * `SIO_CLK_MHZ)

`endif

//--- src/sio_pkg.sv
package sio_pkg;

    // ****************************************
    // chip operating modes
    // ****************************************
    typedef enum logic [2:0]
    {
        SIO_MODE_INIT    = 3'h0,
        SIO_MODE_NORMAL  = 3'h1,
        SIO_MODE_STOP    = 3'h2,
        SIO_MODE_SLEEP   = 3'h3,
        SIO_MODE_RESTART = 3'h4,
        SIO_MODE_FAILSAFE= 3'h5,
        SIO_MODE_SWDEV   = 3'h6,
        SIO_MODE_FLASH   = 3'h7
    } sio_mode_t;

    // interrupt line sequencer
    typedef enum logic [1:0] {SIO_IDLE, SIO_LOW, SIO_GAP} sio_line_t;

endpackage : sio_pkg

//--- src/sio_flag.sv
`include "sio_defines.svh"

// one source flag: event latch, optional state follow and clear hold
module sio_flag
(
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic event_in,
    input  wire logic state_in,
    input  wire logic follow_state,
    input  wire logic hold_in,
    input  wire logic clear_in,
    output logic      flag_q
);

    logic flag_d;
    logic follow_q;
    logic follow_d;

    // ****************************************
    // flag update
    // ****************************************
    // after a read a state flag tracks its condition until the next event
    always_comb
    begin
        flag_d   = follow_q ? state_in : flag_q;
        follow_d = follow_q;
        if (clear_in && !hold_in)
        begin
            flag_d   = follow_state ? state_in : 1'b0;
            follow_d = follow_state;
        end
        if (event_in)
        begin
            flag_d   = 1'b1;                            // set wins over clear
            follow_d = 1'b0;                            // latch until next read
        end
    end

    // tracking mode, entered on a read of a state flag
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            follow_q <= 1'b0;
        end
        else
        begin
            follow_q <= follow_d;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            flag_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

endmodule : sio_flag

//--- src/sio_int_ctrl.sv
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`include "sio_defines.svh"

module sio_int_ctrl
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // chip state
    input  wire logic [2:0]  chip_mode,
    input  wire logic        reset_output_pin,
    // event sources
    input  wire logic        temp_prewarn_evt,
    input  wire logic        reg2_overtemp_evt,
    input  wire logic        can_overtemp_evt,
    input  wire logic        can_fail_evt,
    input  wire logic        reg3_overcur_evt,
    input  wire logic        spi_fail_evt,
    input  wire logic        reset_evt,
    input  wire logic        bad_watchdog_evt,
    input  wire logic        bus_wake_evt,
    input  wire logic        pin_wake_evt,
    input  wire logic        periodic_wake_evt,
    // present conditions
    input  wire logic        temp_prewarn_state,
    input  wire logic        reg2_overtemp_state,
    input  wire logic        can_overtemp_state,
    input  wire logic        can_fail_state,
    input  wire logic        reg3_overcur_state,
    input  wire logic        reg2_undervolt,
    input  wire logic        reg3_undervolt,
    input  wire logic        reg2_on,
    input  wire logic        reg3_on,
    input  wire logic        reg2_switch_on_cmd,
    input  wire logic        reg3_switch_on_cmd,
    // interrupt pin (open drain)
    input  wire logic        int_pin_in,
    output logic             int_pin_out,
    output logic             int_pin_oe,
    output logic             config_24_q
);

    // ****************************************
    // source index map
    // ****************************************
    localparam int W_BUS = 0, W_PIN = 1, W_CYC = 2;
    localparam int F_OTP = 3, F_OT2 = 4, F_OTC = 5, F_CAN = 6, F_SPI = 7;
    localparam int F_RST = 8, F_WD = 9;
    localparam int S_UV2 = 10, S_UV3 = 11, S_OC3 = 12, S_SPARE = 13;
    localparam int CNT_W = 20;
    localparam logic [CNT_W-1:0] PULSE_CYC = CNT_W'(`SIO_MIN_PULSE_CYC);

    parameter int TIMEOUT_CYC = `SIO_TIMEOUT_CYC;
    localparam logic [CNT_W-1:0] TMO_CYC = CNT_W'(TIMEOUT_CYC);

    logic [`SIO_NSRC-1:0] mask_q;
    logic [`SIO_NSRC-1:0] flags;
    logic [`SIO_NSRC-1:0] evt;
    logic [`SIO_NSRC-1:0] state_v;
    logic [`SIO_NSRC-1:0] follow;
    logic [`SIO_NSRC-1:0] hold;
    logic [`SIO_NSRC-1:0] clr;
    logic                 uv2_q;
    logic                 uv3_q;
    logic                 mode_prev_restart_q;
    logic                 active;
    logic                 rd_cmd;
    logic [2:0]           rd_reg;
    logic                 release_rd;
    logic                 pending_q;
    logic                 raise;
    logic [CNT_W-1:0]     cnt_q;
    logic                 summary;
    sio_pkg::sio_line_t   line_q;

    // ****************************************
    // operating mode gating
    // ****************************************
    assign active = (chip_mode == 3'(sio_pkg::SIO_MODE_NORMAL))
                 || (chip_mode == 3'(sio_pkg::SIO_MODE_STOP));

    // ****************************************
    // read-only command decode
    // ****************************************
    assign rd_cmd     = avs_write && !avs_waitrequest && (avs_address == `SIO_OFF_READ_CMD)
                     && (avs_writedata[5:3] == `SIO_RD_ONLY_CODE);
    assign rd_reg     = avs_writedata[2:0];
    assign release_rd = rd_cmd && (rd_reg == `SIO_RD_REG_WAKE);

    // undervoltage edge history, switch-off suppresses
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            uv2_q <= 1'b0;
            uv3_q <= 1'b0;
        end
        else
        begin
            uv2_q <= reg2_undervolt;
            uv3_q <= reg3_undervolt;
        end
    end

    // ****************************************
    // per-source event, state and clear vectors
    // ****************************************
    always_comb
    begin
        evt     = '0;
        state_v = '0;
        follow  = '0;
        hold    = '0;
        clr     = '0;
        evt[W_BUS] = bus_wake_evt;
        evt[W_PIN] = pin_wake_evt;
        evt[W_CYC] = periodic_wake_evt;
        evt[F_OTP] = temp_prewarn_evt;
        evt[F_OT2] = reg2_overtemp_evt;
        evt[F_OTC] = can_overtemp_evt;
        evt[F_CAN] = can_fail_evt;
        evt[F_SPI] = spi_fail_evt;
        evt[F_RST] = reset_evt && (chip_mode == 3'(sio_pkg::SIO_MODE_SWDEV));
        evt[F_WD]  = bad_watchdog_evt;
        // both edges while regulator is on; switch-on command sets flag
        evt[S_UV2] = (reg2_on && (reg2_undervolt != uv2_q)) || reg2_switch_on_cmd;
        evt[S_UV3] = (reg3_on && (reg3_undervolt != uv3_q)) || reg3_switch_on_cmd;
        evt[S_OC3] = reg3_overcur_evt;
        state_v[F_OTP] = temp_prewarn_state;
        state_v[F_OT2] = reg2_overtemp_state;
        state_v[F_OTC] = can_overtemp_state;
        state_v[F_CAN] = can_fail_state;
        state_v[S_UV2] = reg2_on && reg2_undervolt;
        state_v[S_UV3] = reg3_on && reg3_undervolt;
        state_v[S_OC3] = reg3_overcur_state;
        follow[F_OTP] = 1'b1;
        follow[F_OT2] = 1'b1;
        follow[F_OTC] = 1'b1;
        follow[F_CAN] = 1'b1;
        follow[S_UV2] = 1'b1;
        follow[S_UV3] = 1'b1;
        follow[S_OC3] = 1'b1;
        hold[S_UV2] = reg2_on && reg2_undervolt;
        hold[S_UV3] = reg3_on && reg3_undervolt;
        if (rd_cmd)
        begin
            unique case (rd_reg)
                `SIO_RD_REG_WAKE:   clr[W_CYC:W_BUS] = '1;
                `SIO_RD_REG_FAIL:   clr[F_WD:F_OTP]  = '1;
                `SIO_RD_REG_SUPPLY: clr[S_SPARE:S_UV2] = '1;
                default:            clr = '0;
            endcase
        end
    end

    // ****************************************
    // flag storage
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < `SIO_NSRC; gi++)
        begin : g_flag
            sio_flag u_flag
            (
                .core_clk     (core_clk),
                .sys_rst      (sys_rst),
                .event_in     (evt[gi]),
                .state_in     (state_v[gi]),
                .follow_state (follow[gi]),
                .hold_in      (hold[gi]),
                .clear_in     (clr[gi]),
                .flag_q       (flags[gi])
            );
        end
    endgenerate

    // summary follows the non-wake registers
    assign summary = |flags[S_SPARE:F_OTP];

    // ****************************************
    // mask register, all enabled after restart
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            mask_q              <= `SIO_MASK_RESET;
            mode_prev_restart_q <= 1'b0;
        end
        else
        begin
            mode_prev_restart_q <= (chip_mode == 3'(sio_pkg::SIO_MODE_RESTART));
            if (mode_prev_restart_q
                && (chip_mode != 3'(sio_pkg::SIO_MODE_RESTART)))
            begin
                mask_q <= `SIO_MASK_RESET;
            end
            else if (avs_write && !avs_waitrequest && (avs_address == `SIO_OFF_MASK))
            begin
                mask_q <= avs_writedata[`SIO_NSRC-1:0];
            end
        end
    end

    // any enabled event, gated by mode
    assign raise = active && |(evt & mask_q);

    // ****************************************
    // interrupt line sequencer
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            line_q    <= sio_pkg::SIO_IDLE;
            cnt_q     <= '0;
            pending_q <= 1'b0;
        end
        else if (!active)
        begin
            line_q    <= sio_pkg::SIO_IDLE;
            cnt_q     <= '0;
            pending_q <= 1'b0;
        end
        else
        begin
            unique case (line_q)
                sio_pkg::SIO_IDLE:
                begin
                    if (raise || pending_q)
                    begin
                        line_q    <= sio_pkg::SIO_LOW;
                        cnt_q     <= '0;
                        pending_q <= 1'b0;
                    end
                end
                sio_pkg::SIO_LOW:
                begin
                    cnt_q <= cnt_q + CNT_W'(1);
                    // further events merge into this low period
                    if ((release_rd && (cnt_q >= PULSE_CYC - CNT_W'(1)))
                        || (cnt_q >= TMO_CYC - CNT_W'(1)))
                    begin
                        line_q <= sio_pkg::SIO_GAP;
                        cnt_q  <= '0;
                    end
                    else if (release_rd)
                    begin
                        pending_q <= 1'b0;
                    end
                end
                sio_pkg::SIO_GAP:
                begin
                    cnt_q <= cnt_q + CNT_W'(1);
                    if (raise)
                    begin
                        pending_q <= 1'b1;
                    end
                    if (cnt_q >= TMO_CYC - CNT_W'(1))
                    begin
                        line_q <= sio_pkg::SIO_IDLE;
                        cnt_q  <= '0;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // pin drive and configuration strap
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            int_pin_out <= 1'b1;
            int_pin_oe  <= 1'b1;
        end
        else
        begin
            int_pin_out <= 1'b0;
            int_pin_oe  <= !(active && (line_q == sio_pkg::SIO_LOW));
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            config_24_q <= 1'b0;
        end
        else if ((chip_mode == 3'(sio_pkg::SIO_MODE_INIT)) && !reset_output_pin)
        begin
            config_24_q <= int_pin_in;
        end
    end

    // ****************************************
    // avalon slave: one wait state per access
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (avs_read && avs_waitrequest)
        begin
            unique case (avs_address)
                `SIO_OFF_WAKE:
                    avs_readdata <= {28'h0, summary, flags[W_CYC:W_BUS]};
                `SIO_OFF_FAIL:   avs_readdata <= {25'h0, flags[F_WD:F_OTP]};
                `SIO_OFF_SUPPLY: avs_readdata <= {28'h0, flags[S_SPARE:S_UV2]};
                `SIO_OFF_MASK:   avs_readdata <= {18'h0, mask_q};
                `SIO_OFF_STATUS:
                    avs_readdata <= {28'h0, pending_q, config_24_q, line_q};
                `SIO_OFF_MODE:   avs_readdata <= {29'h0, chip_mode};
                default:         avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule : sio_int_ctrl

//--- test/sio_int_ctrl_assertions.sv
// ****
// interrupt line and bus checker
// ****
module sio_int_ctrl_chk
#(
    parameter int TIMEOUT_CYC = 675000
)
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    input  wire logic [2:0]  chip_mode,
    input  wire logic        reset_output_pin,
    input  wire logic        int_pin_out,
    input  wire logic        int_pin_oe,
    input  wire logic        config_24_q
);
    int low_cnt_q;
    int gap_cnt_q;

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // cycles the line has been held low
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || int_pin_oe)
            low_cnt_q <= 0;
        else
            low_cnt_q <= low_cnt_q + 1;
    end

    // cycles since release, saturating
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            gap_cnt_q <= TIMEOUT_CYC;
        else if (!int_pin_oe)
            gap_cnt_q <= 0;
        else if (gap_cnt_q < TIMEOUT_CYC)
            gap_cnt_q <= gap_cnt_q + 1;
    end

    reset_state_a: assert property (
        $fell(sys_rst) |-> int_pin_oe && avs_waitrequest && avs_readdata == 32'h0)
        else $error("outputs wrong after reset");
    drive_zero_a: assert property (!int_pin_oe |-> int_pin_out == 1'b0)
        else $error("line enabled but not driven low");
    ack_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    ack_time_a: assert property (
        $rose(avs_read) || $rose(avs_write) |=> !avs_waitrequest)
        else $error("bus answer late");
    unmapped_a: assert property (
        avs_read && !avs_waitrequest && avs_address == 8'h1C |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    mode_gate_a: assert property (
        $fell(int_pin_oe) |-> $past(chip_mode, 2) inside {3'h1, 3'h2})
        else $error("line asserted outside normal or stop");
    min_pulse_a: assert property ($rose(int_pin_oe) |-> low_cnt_q >= 1250)
        else $error("low pulse shorter than minimum");
    max_low_a: assert property (!int_pin_oe |-> low_cnt_q < TIMEOUT_CYC + 4)
        else $error("line low beyond time-out");
    gap_min_a: assert property ($fell(int_pin_oe) |-> gap_cnt_q >= TIMEOUT_CYC - 2)
        else $error("activations too close");
    cfg_hold_a: assert property (
        reset_output_pin && $past(reset_output_pin) |-> $stable(config_24_q))
        else $error("configuration changed after reset output high");
endmodule : sio_int_ctrl_chk

bind sio_int_ctrl sio_int_ctrl_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u
(
    .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .chip_mode(chip_mode),
    .reset_output_pin(reset_output_pin), .int_pin_out(int_pin_out),
    .int_pin_oe(int_pin_oe), .config_24_q(config_24_q)
);

//--- test/sio_mcu_model.sv
// ****
// microcontroller side of the interrupt pin
// ****
module sio_mcu_model
(
    input  wire logic int_pin_out,
    input  wire logic int_pin_oe,
    input  wire logic strap_low,
    output logic      pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // open-drain wire with pull-up, strap_low pulls the wire low
    assign pin_level = ((!int_pin_oe && !int_pin_out) || strap_low) ? 1'b0 : 1'b1;
endmodule : sio_mcu_model

//--- test/tb.sv
// ****
// interrupt controller testbench
// ****
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TO = 2000;
    logic        core_clk        = 1'b0;
    logic        sys_rst         = 1'b1;
    logic [7:0]  avs_address     = 8'h00;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  chip_mode       = 3'h0;
    logic        rst_out         = 1'b0;
    logic [10:0] evt_v           = 11'h000;
    logic [4:0]  st_v            = 5'h00;
    logic [5:0]  reg_v           = 6'h00;
    logic        strap_low       = 1'b0;
    logic        int_pin_in;
    logic        int_pin_out;
    logic        int_pin_oe;
    logic        config_24_q;
    logic [31:0] rd_q;
    int          n_errors        = 0;
    int          checks_done     = 0;
    int          cyc             = 0;

    sio_int_ctrl #(.TIMEOUT_CYC(TO)) dut_u
    (
        .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .chip_mode(chip_mode), .reset_output_pin(rst_out),
        .temp_prewarn_evt(evt_v[0]), .reg2_overtemp_evt(evt_v[1]),
        .can_overtemp_evt(evt_v[2]), .can_fail_evt(evt_v[3]),
        .reg3_overcur_evt(evt_v[4]), .spi_fail_evt(evt_v[5]), .reset_evt(evt_v[6]),
        .bad_watchdog_evt(evt_v[7]), .bus_wake_evt(evt_v[8]),
        .pin_wake_evt(evt_v[9]), .periodic_wake_evt(evt_v[10]),
        .temp_prewarn_state(st_v[0]), .reg2_overtemp_state(st_v[1]),
        .can_overtemp_state(st_v[2]), .can_fail_state(st_v[3]),
        .reg3_overcur_state(st_v[4]), .reg2_undervolt(reg_v[0]),
        .reg3_undervolt(reg_v[1]), .reg2_on(reg_v[2]), .reg3_on(reg_v[3]),
        .reg2_switch_on_cmd(reg_v[4]), .reg3_switch_on_cmd(reg_v[5]),
        .int_pin_in(int_pin_in), .int_pin_out(int_pin_out),
        .int_pin_oe(int_pin_oe), .config_24_q(config_24_q)
    );

    sio_mcu_model mcu_u
    (
        .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe),
        .strap_low(strap_low), .pin_level(int_pin_in)
    );

    // clock and hang guard
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_errors++;
            complete_run();
        end
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
        begin
            @(posedge core_clk);
        end
        rd_q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd_q, exp);
    endtask : rd

    task automatic pulse(input int i);
        evt_v <= 11'h001 << i;
        @(posedge core_clk);
        evt_v <= 11'h000;
    endtask : pulse

    task automatic wait_oe(input logic lv, input int mx, output int c);
        c = 0;
        while (int_pin_oe !== lv && c < mx)
        begin
            @(posedge core_clk);
            c++;
        end
    endtask : wait_oe

    task automatic t_reset;
        rd(8'h0C, 32'h3FFF);
        rd(8'h00, 32'h0);
        bus(1'b1, 8'h1C, 32'hFFFFFFFF);
        rd(8'h1C, 32'h0);
        chk(config_24_q, 1'b1);
        rd(8'h10, 32'h4);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_masked;
        int c;
        bus(1'b1, 8'h0C, 32'h0);
        pulse(8);
        wait_oe(1'b0, 20, c);
        chk(c, 20);
        rd(8'h00, 32'h1);
        bus(1'b1, 8'h14, 32'h38);
        rd(8'h00, 32'h0);
        chip_mode <= sio_pkg::SIO_MODE_RESTART;
        @(posedge core_clk);
        chip_mode <= sio_pkg::SIO_MODE_NORMAL;
        repeat (2) @(posedge core_clk);
        rd(8'h0C, 32'h3FFF);
        $display("t_masked done");
    endtask : t_masked

    task automatic t_release;
        int c;
        pulse(8);
        wait_oe(1'b0, 5, c);
        chk(c < 5, 1'b1);
        bus(1'b1, 8'h14, 32'h38);
        chk(int_pin_oe, 1'b0);
        wait_oe(1'b1, TO, c);
        chk(c < TO, 1'b1);
        repeat (TO + 10) @(posedge core_clk);
        pulse(9);
        wait_oe(1'b0, 5, c);
        chk(c < 5, 1'b1);
        repeat (1300) @(posedge core_clk);
        bus(1'b1, 8'h14, 32'h38);
        wait_oe(1'b1, 5, c);
        chk(c < 5, 1'b1);
        rd(8'h00, 32'h0);
        $display("t_release done");
    endtask : t_release

    task automatic t_gap;
        int c;
        st_v <= 5'h01;
        pulse(0);
        @(posedge core_clk);
        pulse(7);
        wait_oe(1'b0, TO + 100, c);
        chk(c > TO - 100, 1'b1);
        rd(8'h00, 32'h8);
        rd(8'h04, 32'h41);
        wait_oe(1'b1, TO + 10, c);
        chk(c > TO - 100, 1'b1);
        rd(8'h04, 32'h41);
        bus(1'b1, 8'h14, 32'h39);
        rd(8'h04, 32'h1);
        st_v <= 5'h00;
        repeat (2) @(posedge core_clk);
        rd(8'h04, 32'h0);
        rd(8'h00, 32'h0);
        $display("t_gap done");
    endtask : t_gap

    task automatic t_mode;
        int c;
        repeat (TO + 10) @(posedge core_clk);
        chip_mode <= sio_pkg::SIO_MODE_SLEEP;
        @(posedge core_clk);
        pulse(10);
        wait_oe(1'b0, 20, c);
        chk(c, 20);
        chip_mode <= sio_pkg::SIO_MODE_NORMAL;
        bus(1'b1, 8'h14, 32'h38);
        $display("t_mode done");
    endtask : t_mode

    task automatic t_supply;
        int c;
        reg_v <= 6'h15;
        @(posedge core_clk);
        reg_v <= 6'h05;
        wait_oe(1'b0, 5, c);
        chk(c < 5, 1'b1);
        bus(1'b1, 8'h14, 32'h3A);
        rd(8'h08, 32'h1);
        wait_oe(1'b1, TO + 10, c);
        chk(c < TO + 10, 1'b1);
        reg_v <= 6'h04;
        @(posedge core_clk);
        rd(8'h10, 32'hE);
        bus(1'b1, 8'h14, 32'h3A);
        rd(8'h08, 32'h0);
        reg_v <= 6'h00;
        @(posedge core_clk);
        reg_v <= 6'h01;
        repeat (2) @(posedge core_clk);
        rd(8'h08, 32'h0);
        pulse(6);
        rd(8'h04, 32'h0);
        chip_mode <= sio_pkg::SIO_MODE_SWDEV;
        @(posedge core_clk);
        pulse(6);
        rd(8'h04, 32'h20);
        rd(8'h10, 32'h4);
        bus(1'b1, 8'h14, 32'h39);
        rd(8'h04, 32'h0);
        chip_mode <= sio_pkg::SIO_MODE_NORMAL;
        $display("t_supply done");
    endtask : t_supply

    // reset, strap sampled high, pin then pulled low, then the scenarios
    initial
    begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        chip_mode <= sio_pkg::SIO_MODE_NORMAL;
        rst_out <= 1'b1;
        strap_low <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_masked();
        t_release();
        t_gap();
        t_mode();
        t_supply();
        complete_run();
    end
endmodule : tb
